/* File: design/capture_compare_unit_defs.vh */
// Summary of operation
// R01: Capture latches selected timer on chosen event.
// R02: Compare match on selected timer changes channel output.
// R03: Successive matches form timing sequences and PWM.
// R04: At most ten separate interrupt outputs.
// R05: Each interrupt picks channel, pin or timer source.
// R06: Two 16-bit timers, either serves any channel.
// R07: Pins carry channel signal only when selected.
// R08: First channel pin doubles as SPI interrupt input.
// R09: Pins undriven with pull-down during and after reset.
// R10: Timers step once per tick, wrap to zero.
// R11: Interrupt flags stay set until software clears.
`ifndef UNIT_DEFS_VH
`define UNIT_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define ADDR_TCTRL 6'h00
`define ADDR_PRESC 6'h04
`define ADDR_T0_TOP 6'h08
`define ADDR_T1_TOP 6'h0c
`define ADDR_T0_CNT 6'h10
`define ADDR_T1_CNT 6'h14
`define ADDR_CH0_CFG 6'h18
`define ADDR_CH1_CFG 6'h1c
`define ADDR_CH0_VAL 6'h20
`define ADDR_CH1_VAL 6'h24
`define ADDR_GPIO 6'h28
`define ADDR_INT_STAT 6'h2c
`define ADDR_INT_MASK 6'h30
`define ADDR_INT_SEL 6'h34

// Timer control fields.
`define TCTRL_EN0 0
`define TCTRL_EN1 1
`define TCTRL_CLR0 2
`define TCTRL_CLR1 3

// Channel configuration fields.
`define CFG_MODE_LSB 0
`define CFG_TSEL 2
`define CFG_EDGE_LSB 3
`define CFG_ACT_LSB 5
`define CFG_WRAP_SET 7
`define CFG_W 8

// Channel modes.
`define MODE_GPIO 2'h0
`define MODE_CAP 2'h1
`define MODE_CMP 2'h2

// Capture event choices.
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`define EDGE_INT 2'h3

// Compare match actions.
`define ACT_SET 2'h0
`define ACT_CLR 2'h1
`define ACT_TOG 2'h2

// GPIO register fields.
`define GPIO_OUT_LSB 0
`define GPIO_OE_LSB 2
`define GPIO_IN_LSB 4

// Interrupt source codes.
`define SRC_NONE 3'h0
`define SRC_CH0 3'h1
`define SRC_CH1 3'h2
`define SRC_PIN_A 3'h3
`define SRC_PIN_B 3'h4
`define SRC_T0 3'h5
`define SRC_T1 3'h6
`define SRC_W 3

// Reset values.
`define RST_TOP 16'hffff
`define RST_PRESC 32'h00000000
`define RST_CFG 8'h00

`endif

/* File: design/capture_compare_unit_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_unit_defs.vh"

module tick_timer #(
   parameter W = 16
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire en_i,
   input wire clr_i,
   input wire [W-1:0] div_i,
   input wire [W-1:0] top_i,
   output wire [W-1:0] count_o,
   output wire step_o,
   output wire wrap_o
);

   reg [W-1:0] pre_q;
   reg [W-1:0] cnt_q;
   reg step_q;
   reg wrap_q;

   // A tick occurs every div_i+1 clocks; step and wrap pulse one cycle.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         pre_q <= {W{1'b0}};
         cnt_q <= {W{1'b0}};
         step_q <= 1'b0;
         wrap_q <= 1'b0;
      end else if (clr_i) begin
         pre_q <= {W{1'b0}};
         cnt_q <= {W{1'b0}};
         step_q <= 1'b0;
         wrap_q <= 1'b0;
      end else begin
         step_q <= 1'b0;
         wrap_q <= 1'b0;
         if (en_i) begin
            if (pre_q >= div_i) begin
               pre_q <= {W{1'b0}};
               step_q <= 1'b1;
               if (cnt_q >= top_i) begin
                  cnt_q <= {W{1'b0}}; // R10
                  wrap_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1}; // R10
               end
            end else begin
               pre_q <= pre_q + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign count_o = cnt_q;
   assign step_o = step_q;
   assign wrap_o = wrap_q;

endmodule
`default_nettype wire

/* File: design/capture_compare_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_unit_defs.vh"

module capture_compare_unit #(
   parameter CNT_W = 16,
   parameter NUM_IRQ = 10
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire channel_pin_a_i,
   output wire channel_pin_a_o,
   output wire channel_pin_a_oe_b_o,
   output wire channel_pin_a_pd_o,
   input wire channel_pin_b_i,
   output wire channel_pin_b_o,
   output wire channel_pin_b_oe_b_o,
   output wire channel_pin_b_pd_o,
   output wire spi_irq_o,
   output wire [NUM_IRQ-1:0] irq_lines_o,
   output wire irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   reg wait_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   reg [1:0] ten_q;
   reg [31:0] presc_q;
   reg [CNT_W-1:0] top0_q;
   reg [CNT_W-1:0] top1_q;
   reg [2*`CFG_W-1:0] cfg_q;
   reg [2*CNT_W-1:0] val_q;
   reg [1:0] out_q;
   reg [1:0] gout_q;
   reg [1:0] goe_q;
   reg [NUM_IRQ-1:0] stat_q;
   reg [NUM_IRQ-1:0] mask_q;
   reg [`SRC_W*NUM_IRQ-1:0] isel_q;
   reg [1:0] s1_q;
   reg [1:0] s2_q;
   reg [1:0] s3_q;
   reg [1:0] lvl_q;
   reg [1:0] lvl_prev_q;
   reg [1:0] pin_o_q;
   reg [1:0] oe_b_q;
   reg [1:0] pd_q;
   reg spi_irq_q;
   reg [NUM_IRQ-1:0] lines_q;
   reg irq_q;
   wire [2*CNT_W-1:0] cnt_w;
   wire [1:0] step_w;
   wire [1:0] wrap_w;
   wire [1:0] pin_in;
   wire [1:0] agree;
   wire [1:0] rise;
   wire [1:0] fall;
   wire req_seen;
   wire wr_go;
   reg [1:0] cap_ev;
   reg [1:0] cmp_ev;
   reg [1:0] twrap;
   reg [1:0] drive;
   reg [2*CNT_W-1:0] tcount;
   reg [7:0] src;
   reg [NUM_IRQ-1:0] set_v;
   integer c, cr, cd, cp;
   integer k;
   genvar t;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.
   // Returns the count of the timer a channel has selected.
   function [CNT_W-1:0] pick_count;
      input sel;
      input [2*CNT_W-1:0] counts;
      begin
         pick_count = sel ? counts[2*CNT_W-1:CNT_W] : counts[CNT_W-1:0];
      end
   endfunction

   // Returns the timer pulse of the selected or of the other timer.
   function pick_bit;
      input sel;
      input [1:0] bits;
      begin
         pick_bit = sel ? bits[1] : bits[0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then writes land and read data stand.
   assign req_seen = (avs_read_i | avs_write_i) & wait_q;
   assign wr_go = avs_write_i & ~wait_q;

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= ~req_seen;
         if (req_seen & avs_read_i) begin
            rdata_q <= rdata_d;
         end
      end
   end

   always @* begin
      rdata_d = 32'h00000000;
      if (avs_address_i == `ADDR_TCTRL) begin
         rdata_d = {30'h00000000, ten_q};
      end else if (avs_address_i == `ADDR_PRESC) begin
         rdata_d = presc_q;
      end else if (avs_address_i == `ADDR_T0_TOP) begin
         rdata_d[CNT_W-1:0] = top0_q;
      end else if (avs_address_i == `ADDR_T1_TOP) begin
         rdata_d[CNT_W-1:0] = top1_q;
      end else if (avs_address_i == `ADDR_T0_CNT) begin
         rdata_d[CNT_W-1:0] = cnt_w[CNT_W-1:0];
      end else if (avs_address_i == `ADDR_T1_CNT) begin
         rdata_d[CNT_W-1:0] = cnt_w[2*CNT_W-1:CNT_W];
      end else if (avs_address_i == `ADDR_CH0_CFG) begin
         rdata_d[`CFG_W-1:0] = cfg_q[`CFG_W-1:0];
      end else if (avs_address_i == `ADDR_CH1_CFG) begin
         rdata_d[`CFG_W-1:0] = cfg_q[2*`CFG_W-1:`CFG_W];
      end else if (avs_address_i == `ADDR_CH0_VAL) begin
         rdata_d[CNT_W-1:0] = val_q[CNT_W-1:0];
      end else if (avs_address_i == `ADDR_CH1_VAL) begin
         rdata_d[CNT_W-1:0] = val_q[2*CNT_W-1:CNT_W];
      end else if (avs_address_i == `ADDR_GPIO) begin
         rdata_d[`GPIO_OUT_LSB+1:`GPIO_OUT_LSB] = gout_q;
         rdata_d[`GPIO_OE_LSB+1:`GPIO_OE_LSB] = goe_q;
         rdata_d[`GPIO_IN_LSB+1:`GPIO_IN_LSB] = lvl_q;
      end else if (avs_address_i == `ADDR_INT_STAT) begin
         rdata_d[NUM_IRQ-1:0] = stat_q;
      end else if (avs_address_i == `ADDR_INT_MASK) begin
         rdata_d[NUM_IRQ-1:0] = mask_q;
      end else if (avs_address_i == `ADDR_INT_SEL) begin
         rdata_d[`SRC_W*NUM_IRQ-1:0] = isel_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers written by software.

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         ten_q <= 2'h0;
         presc_q <= `RST_PRESC;
         top0_q <= `RST_TOP;
         top1_q <= `RST_TOP;
         gout_q <= 2'h0;
         goe_q <= 2'h0;
         mask_q <= {NUM_IRQ{1'b0}};
         isel_q <= {(`SRC_W*NUM_IRQ){1'b0}};
      end else if (wr_go) begin
         if (avs_address_i == `ADDR_TCTRL) begin
            ten_q <= avs_writedata_i[`TCTRL_EN1:`TCTRL_EN0];
         end else if (avs_address_i == `ADDR_PRESC) begin
            presc_q <= avs_writedata_i;
         end else if (avs_address_i == `ADDR_T0_TOP) begin
            top0_q <= avs_writedata_i[CNT_W-1:0];
         end else if (avs_address_i == `ADDR_T1_TOP) begin
            top1_q <= avs_writedata_i[CNT_W-1:0];
         end else if (avs_address_i == `ADDR_GPIO) begin
            gout_q <= avs_writedata_i[`GPIO_OUT_LSB+1:`GPIO_OUT_LSB];
            goe_q <= avs_writedata_i[`GPIO_OE_LSB+1:`GPIO_OE_LSB];
         end else if (avs_address_i == `ADDR_INT_MASK) begin
            mask_q <= avs_writedata_i[NUM_IRQ-1:0];
         end else if (avs_address_i == `ADDR_INT_SEL) begin
            isel_q <= avs_writedata_i[`SRC_W*NUM_IRQ-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two timers, either one usable by any channel.

   generate
      for (t = 0; t < 2; t = t + 1) begin : g_tmr
         tick_timer #(
            .W(CNT_W)
         ) u_tmr (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .en_i(ten_q[t]),
            .clr_i(wr_go && (avs_address_i == `ADDR_TCTRL) &&
                   avs_writedata_i[`TCTRL_CLR0+t]),
            .div_i(presc_q[t*16 +: CNT_W]),
            .top_i(t == 0 ? top0_q : top1_q),
            .count_o(cnt_w[t*CNT_W +: CNT_W]),
            .step_o(step_w[t]),
            .wrap_o(wrap_w[t])
         ); // R06
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers: a level counts once stages two and three agree.

   assign pin_in = {channel_pin_b_i, channel_pin_a_i};
   assign agree = ~(s2_q ^ s3_q);
   assign rise = lvl_q & ~lvl_prev_q;
   assign fall = ~lvl_q & lvl_prev_q;

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
         lvl_q <= 2'h0;
         lvl_prev_q <= 2'h0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (agree & s3_q) | (~agree & lvl_q);
         lvl_prev_q <= lvl_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel events.

   always @* begin
      cap_ev = 2'h0;
      cmp_ev = 2'h0;
      twrap = 2'h0;
      tcount = {(2*CNT_W){1'b0}};
      for (c = 0; c < 2; c = c + 1) begin
         tcount[c*CNT_W +: CNT_W] =
            pick_count(cfg_q[c*`CFG_W+`CFG_TSEL], cnt_w);
         twrap[c] = pick_bit(cfg_q[c*`CFG_W+`CFG_TSEL], wrap_w);
         if (cfg_q[c*`CFG_W+`CFG_MODE_LSB +: 2] == `MODE_CAP) begin
            case (cfg_q[c*`CFG_W+`CFG_EDGE_LSB +: 2])
               `EDGE_RISE: cap_ev[c] = rise[c]; // R01
               `EDGE_FALL: cap_ev[c] = fall[c]; // R01
               `EDGE_BOTH: cap_ev[c] = rise[c] | fall[c]; // R01
               default: cap_ev[c] =
                  pick_bit(~cfg_q[c*`CFG_W+`CFG_TSEL], wrap_w); // R01
            endcase
         end
         if (cfg_q[c*`CFG_W+`CFG_MODE_LSB +: 2] == `MODE_CMP) begin
            cmp_ev[c] = pick_bit(cfg_q[c*`CFG_W+`CFG_TSEL], step_w) &&
               (tcount[c*CNT_W +: CNT_W] == val_q[c*CNT_W +: CNT_W]); // R02
         end
      end
   end

   // Capture takes priority over a software write to the value register.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         cfg_q <= {2{`RST_CFG}};
         val_q <= {(2*CNT_W){1'b0}};
         out_q <= 2'h0;
      end else begin
         for (cr = 0; cr < 2; cr = cr + 1) begin
            if (wr_go &&
                  (avs_address_i == `ADDR_CH0_CFG + {cr[3:0], 2'h0})) begin
               cfg_q[cr*`CFG_W +: `CFG_W] <= avs_writedata_i[`CFG_W-1:0];
            end
            if (cap_ev[cr]) begin
               val_q[cr*CNT_W +: CNT_W] <= tcount[cr*CNT_W +: CNT_W]; // R01
            end else if (wr_go &&
                  (avs_address_i == `ADDR_CH0_VAL + {cr[3:0], 2'h0})) begin
               val_q[cr*CNT_W +: CNT_W] <= avs_writedata_i[CNT_W-1:0];
            end
            if (cmp_ev[cr]) begin
               case (cfg_q[cr*`CFG_W+`CFG_ACT_LSB +: 2])
                  `ACT_SET: out_q[cr] <= 1'b1; // R02
                  `ACT_CLR: out_q[cr] <= 1'b0; // R02
                  default: out_q[cr] <= ~out_q[cr]; // R03
               endcase
            end else if (twrap[cr] && cfg_q[cr*`CFG_W+`CFG_WRAP_SET]) begin
               out_q[cr] <= 1'b1; // R03
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers: channel output in compare mode, GPIO when unselected.

   always @* begin
      for (cd = 0; cd < 2; cd = cd + 1) begin
         if (cfg_q[cd*`CFG_W+`CFG_MODE_LSB +: 2] == `MODE_CMP) begin
            drive[cd] = 1'b1; // R07
         end else if (cfg_q[cd*`CFG_W+`CFG_MODE_LSB +: 2] == `MODE_GPIO) begin
            drive[cd] = goe_q[cd]; // R07
         end else begin
            drive[cd] = 1'b0;
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_o_q <= 2'h0; // R09
         oe_b_q <= 2'h3; // R09
         pd_q <= 2'h3; // R09
         spi_irq_q <= 1'b0;
      end else begin
         for (cp = 0; cp < 2; cp = cp + 1) begin
            if (cfg_q[cp*`CFG_W+`CFG_MODE_LSB +: 2] == `MODE_CMP) begin
               pin_o_q[cp] <= out_q[cp]; // R07
            end else begin
               pin_o_q[cp] <= gout_q[cp]; // R07
            end
         end
         oe_b_q <= ~drive;
         pd_q <= ~drive;
         spi_irq_q <= lvl_q[0]; // R08
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: a selectable source per line, sticky status, mask.

   always @* begin
      src = 8'h00;
      src[`SRC_CH0] = cap_ev[0] | cmp_ev[0];
      src[`SRC_CH1] = cap_ev[1] | cmp_ev[1];
      src[`SRC_PIN_A] = rise[0] | fall[0];
      src[`SRC_PIN_B] = rise[1] | fall[1];
      src[`SRC_T0] = wrap_w[0];
      src[`SRC_T1] = wrap_w[1];
      set_v = {NUM_IRQ{1'b0}};
      for (k = 0; k < NUM_IRQ; k = k + 1) begin
         set_v[k] = src[isel_q[k*`SRC_W +: `SRC_W]]; // R05
      end
   end

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         stat_q <= {NUM_IRQ{1'b0}};
         lines_q <= {NUM_IRQ{1'b0}};
         irq_q <= 1'b0;
      end else begin
         if (wr_go && (avs_address_i == `ADDR_INT_STAT)) begin
            stat_q <= (stat_q & ~avs_writedata_i[NUM_IRQ-1:0]) | set_v; // R11
         end else begin
            stat_q <= stat_q | set_v; // R11
         end
         lines_q <= stat_q & mask_q; // R04
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign channel_pin_a_o = pin_o_q[0];
   assign channel_pin_a_oe_b_o = oe_b_q[0];
   assign channel_pin_a_pd_o = pd_q[0];
   assign channel_pin_b_o = pin_o_q[1];
   assign channel_pin_b_oe_b_o = oe_b_q[1];
   assign channel_pin_b_pd_o = pd_q[1];
   assign spi_irq_o = spi_irq_q;
   assign irq_lines_o = lines_q;
   assign irq_o = irq_q;
endmodule
`default_nettype wire

/* File: dv/pin_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
   input wire logic drive_i,
   input wire logic oe_b_i,
   input wire logic pd_i,
   input wire logic ext_en_i,
   input wire logic ext_i,
   output logic level_o
);
   // An undriven pin without pull-down is shown high, so a stale low
   // never passes for a driven one.
   assign level_o = !oe_b_i ? drive_i : ext_en_i ? ext_i : pd_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: dv/capture_compare_unit_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit_assertions #(
   parameter NUM_IRQ = 10
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic channel_pin_a_i,
   input wire logic channel_pin_a_oe_b_o,
   input wire logic channel_pin_a_pd_o,
   input wire logic channel_pin_b_oe_b_o,
   input wire logic channel_pin_b_pd_o,
   input wire logic spi_irq_o,
   input wire logic [NUM_IRQ-1:0] irq_lines_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence accept_s;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence answer_s;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   wait_once_a: assert property (accept_s |=> answer_s)
      else $error("waitrequest not low for one cycle");
   rdata_hold_a: assert property (!(avs_read_i && avs_waitrequest_o)
      |=> $stable(avs_readdata_o)) else $error("read data moved");
   reset_pins_a: assert property ($rose(rst_b_i) |->
      channel_pin_a_oe_b_o && channel_pin_a_pd_o && channel_pin_b_oe_b_o
      && channel_pin_b_pd_o && !irq_o && !spi_irq_o)
      else $error("pins not released after reset");
   pull_down_a: assert property (
      channel_pin_a_pd_o == channel_pin_a_oe_b_o
      && channel_pin_b_pd_o == channel_pin_b_oe_b_o)
      else $error("pull-down not on while undriven");
   irq_or_a: assert property (irq_o == |irq_lines_o)
      else $error("irq differs from its lines");
   spi_follow_a: assert property ($stable(channel_pin_a_i)[*8]
      |-> spi_irq_o == channel_pin_a_i) else $error("spi irq not pin a");
   sticky_irq_a: assert property (
      |($past(irq_lines_o) & ~irq_lines_o) |-> $past(avs_write_i)
      || $past(avs_write_i, 2) || $past(avs_write_i, 3))
      else $error("interrupt line fell without a write");
   drive_on_write_a: assert property (
      $fell(channel_pin_a_oe_b_o) || $fell(channel_pin_b_oe_b_o)
      |-> $past(avs_write_i) || $past(avs_write_i, 2)
      || $past(avs_write_i, 3)) else $error("pin driven without a write");
endmodule
bind capture_compare_unit capture_compare_unit_assertions #(
   .NUM_IRQ(NUM_IRQ)
) capture_compare_unit_assertions_inst (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .channel_pin_a_i(channel_pin_a_i),
   .channel_pin_a_oe_b_o(channel_pin_a_oe_b_o),
   .channel_pin_a_pd_o(channel_pin_a_pd_o),
   .channel_pin_b_oe_b_o(channel_pin_b_oe_b_o),
   .channel_pin_b_pd_o(channel_pin_b_pd_o),
   .spi_irq_o(spi_irq_o),
   .irq_lines_o(irq_lines_o),
   .irq_o(irq_o)
);
`default_nettype wire

/* File: dv/tb_capture_compare_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_unit_defs.vh"
module tb_capture_compare_unit;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [5:0] addr = 6'h00;
   logic rd_en = 1'b0, wr_en = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic ext_en_a = 1'b0, ext_a = 1'b0, ext_en_b = 1'b0, ext_b = 1'b0;
   wire [31:0] rdata;
   wire waitreq, pin_a, pin_b, a_o, a_oe_b, a_pd, b_o, b_oe_b, b_pd;
   wire spi_irq, irq;
   wire [9:0] irq_lines;
   integer failures = 0;
   integer total_checks = 0;
   integer i, r1, r2, hi;
   logic [31:0] rd, c0, v, sel;
   logic [7:0] seen;
   logic p;

   always #2 clk_i = ~clk_i;

   capture_compare_unit capture_compare_unit_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .channel_pin_a_i(pin_a), .channel_pin_a_o(a_o),
      .channel_pin_a_oe_b_o(a_oe_b), .channel_pin_a_pd_o(a_pd),
      .channel_pin_b_i(pin_b), .channel_pin_b_o(b_o),
      .channel_pin_b_oe_b_o(b_oe_b), .channel_pin_b_pd_o(b_pd),
      .spi_irq_o(spi_irq), .irq_lines_o(irq_lines), .irq_o(irq));
   pin_source_model pin_source_model_a (.drive_i(a_o), .oe_b_i(a_oe_b),
      .pd_i(a_pd), .ext_en_i(ext_en_a), .ext_i(ext_a), .level_o(pin_a));
   pin_source_model pin_source_model_b (.drive_i(b_o), .oe_b_i(b_oe_b),
      .pd_i(b_pd), .ext_en_i(ext_en_b), .ext_i(ext_b), .level_o(pin_b));

   ////////////////////////////////////////////////////////////////////////
   task expect_true(input logic ok, input string what);
      total_checks = total_checks + 1;
      if (ok !== 1'b1) begin
         failures = failures + 1;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   // One Avalon-MM transfer; read data lands in rd.
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      rd_en <= !wr;
      wr_en <= wr;
      n = 0;
      @(posedge clk_i);
      while (waitreq !== 1'b0 && n < 20) begin
         @(posedge clk_i);
         n = n + 1;
      end
      if (n == 20) expect_true(1'b0, "bus timeout");
      rd = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask

   task complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      expect_true(a_oe_b === 1'b1 && a_pd === 1'b1, "pin a drive");
      expect_true(b_oe_b === 1'b1 && b_pd === 1'b1, "pin b drive");
      expect_true(irq === 1'b0 && irq_lines === 10'h000, "irq");
      bus(0, `ADDR_T0_TOP, 0);
      expect_true(rd === 32'h0000ffff, "t0 top reset");
      bus(0, `ADDR_CH1_CFG, 0);
      expect_true(rd === 32'h00000000, "cfg reset");
      bus(0, 6'h3c, 0);
      expect_true(rd === 32'h00000000, "unmapped read");
      $display("t_reset done");
   endtask

   task t_gpio;
      bus(1, `ADDR_GPIO, 32'h0000000d);
      repeat (8) @(posedge clk_i);
      expect_true(a_oe_b === 1'b0 && a_o === 1'b1 && a_pd === 1'b0, "a");
      expect_true(b_oe_b === 1'b0 && b_o === 1'b0, "b out");
      bus(0, `ADDR_GPIO, 0);
      expect_true(rd[5:0] === 6'h1d, "gpio readback");
      ext_en_a <= 1'b1;
      ext_en_b <= 1'b1;
      ext_b <= 1'b1;
      bus(1, `ADDR_GPIO, 0);
      repeat (8) @(posedge clk_i);
      bus(0, `ADDR_GPIO, 0);
      expect_true(rd[5:0] === 6'h20 && a_pd === 1'b1, "gpio input");
      $display("t_gpio done");
   endtask

   task t_timer;
      seen = 8'h00;
      bus(1, `ADDR_PRESC, 0);
      bus(1, `ADDR_T0_TOP, 32'h00000004);
      bus(1, `ADDR_TCTRL, 32'h00000001);
      for (i = 0; i < 12; i = i + 1) begin
         bus(0, `ADDR_T0_CNT, 0);
         expect_true(rd <= 32'h00000004, "count above top");
         seen[rd[2:0]] = 1'b1;
      end
      expect_true(seen === 8'h1f, "count values");
      $display("t_timer done");
   endtask

   task t_capture;
      bus(1, `ADDR_T0_TOP, 32'h0000ffff);
      bus(1, `ADDR_CH0_CFG, 32'h00000001);
      bus(1, `ADDR_INT_SEL, 32'h00000019);
      bus(1, `ADDR_INT_MASK, 32'h00000003);
      bus(1, `ADDR_INT_STAT, 32'h000003ff);
      bus(0, `ADDR_T0_CNT, 0);
      c0 = rd;
      ext_a <= 1'b1;
      repeat (12) @(posedge clk_i);
      bus(0, `ADDR_CH0_VAL, 0);
      v = rd;
      bus(0, `ADDR_T0_CNT, 0);
      expect_true(v > c0 && v < rd, "capture value");
      expect_true(spi_irq === 1'b1 && a_oe_b === 1'b1, "pin a in");
      bus(0, `ADDR_INT_STAT, 0);
      expect_true(rd[9:0] === 10'h003, "flags");
      bus(1, `ADDR_INT_STAT, 32'h00000001);
      bus(0, `ADDR_INT_STAT, 0);
      expect_true(rd[9:0] === 10'h002 && irq === 1'b1, "sticky");
      bus(1, `ADDR_INT_MASK, 0);
      repeat (3) @(posedge clk_i);
      expect_true(irq === 1'b0 && irq_lines === 10'h000, "mask");
      $display("t_capture done");
   endtask

   task t_pwm;
      r1 = -1;
      r2 = -1;
      hi = 0;
      ext_en_b <= 1'b0;
      bus(1, `ADDR_T1_TOP, 32'h0000000f);
      bus(1, `ADDR_CH1_VAL, 32'h00000004);
      bus(1, `ADDR_CH1_CFG, 32'h000000a6);
      bus(1, `ADDR_TCTRL, 32'h00000003);
      repeat (40) @(posedge clk_i);
      p = b_o;
      for (i = 0; i < 64; i = i + 1) begin
         @(posedge clk_i);
         if (b_o === 1'b1 && p === 1'b0) begin
            if (r1 < 0) r1 = i;
            else if (r2 < 0) r2 = i;
         end
         if (r1 >= 0 && r2 < 0 && b_o === 1'b1) hi = hi + 1;
         p = b_o;
      end
      expect_true(r2 - r1 == 16, "pwm period");
      expect_true(hi >= 3 && hi <= 6, "pwm duty");
      expect_true(b_oe_b === 1'b0, "pin b driven");
      $display("t_pwm done");
   endtask

   task t_irq_sel;
      sel = 32'h00000000;
      for (i = 0; i < 8; i = i + 1) sel = sel | (i << (3 * i));
      bus(1, `ADDR_INT_SEL, sel);
      bus(1, `ADDR_CH0_CFG, 32'h00000019);
      bus(1, `ADDR_CH1_CFG, 32'h00000046);
      bus(1, `ADDR_T0_TOP, 32'h00000007);
      bus(1, `ADDR_TCTRL, 32'h00000007);
      bus(1, `ADDR_INT_MASK, 32'h000003ff);
      bus(1, `ADDR_INT_STAT, 32'h000003ff);
      ext_a <= 1'b0;
      repeat (40) @(posedge clk_i);
      expect_true(irq_lines === 10'h07e && irq === 1'b1, "sources");
      expect_true(spi_irq === 1'b0, "spi irq low");
      $display("t_irq_sel done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      t_reset;
      t_gpio;
      t_timer;
      t_capture;
      t_pwm;
      t_irq_sel;
      complete_run;
   end

   initial begin
      #100000;
      failures = failures + 1;
      complete_run;
   end
endmodule
`default_nettype wire
